//--- pkg/pulsed_converter_control_sequencer_defines.vh
`ifndef PULSED_CONVERTER_CONTROL_SEQUENCER_DEFINES_VH
`define PULSED_CONVERTER_CONTROL_SEQUENCER_DEFINES_VH

`define OFS_CTRL        12'h000
`define OFS_RATE        12'h004
`define OFS_STATUS      12'h008
`define OFS_FAULT       12'h00C

`define CTRL_OFF        0
`define CTRL_STBY       1
`define CTRL_RUN        2
`define CTRL_CLR        3
`define CTRL_FREE       4
`define CTRL_SHOT       5
`define CTRL_RST        6'h01

`define RATE_RST        12'h3E8
`define RATE_MIN_MS     12'h3E8
`define RATE_MAX_MS     12'hD05

`define STAT_OFF        0
`define STAT_STBY       1
`define STAT_RUN        2
`define STAT_HEALTHY    3
`define STAT_REMOTE     4
`define STAT_SEQ_LSB    5
`define STAT_IND_LSB    8

`define IND_INT_FAULT   0
`define IND_EXT_FAULT   1
`define IND_TMG_WARN    2
`define IND_CMD_WARN    3
`define IND_SIM_ACTIVE  4

`define CLK_HZ          10000000
`define MS_CYC          (`CLK_HZ / 1000)
`define DIV_W           14
`define WIN_MS          20
`define BLOCK_MS        2
`define RECOV_MS        10
`define CHARGE_GUARD_MS 500
`define SAMPLE_GUARD_MS 5

`endif

//--- design/pulsed_converter_control_sequencer.v
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`include "pulsed_converter_control_sequencer_defines.vh"

module pulsed_converter_control_sequencer #(
    parameter DET_W  = 4,
    parameter MS_CYC = `MS_CYC
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              ce,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output wire              pslverr,
    input  wire              mode_remote,
    input  wire [3:0]        local_cmd,
    input  wire              local_shot,
    input  wire              ext_charge_begin,
    input  wire              ext_charge_end,
    input  wire              ext_discharge,
    input  wire              ext_sample,
    input  wire              int_fault,
    input  wire              ext_fault,
    input  wire [DET_W-1:0]  det_fault,
    output wire              contactor_close,
    output wire              electronics_enable,
    output wire              stat_off,
    output wire              stat_standby,
    output wire              stat_run,
    output wire              remote_healthy,
    output wire [7:0]        indicator,
    output wire [DET_W+1:0]  panel_fault,
    output reg               charge_active,
    output reg               charge_begin_pulse,
    output reg               charge_end_pulse,
    output reg               discharge_fire_pulse,
    output reg               sample_pulse
);

    localparam ST_OFF   = 2'd0;
    localparam ST_STBY  = 2'd1;
    localparam ST_RUN   = 2'd2;

    localparam S_IDLE   = 3'd0;
    localparam S_CHARGE = 3'd1;
    localparam S_BLOCK  = 3'd2;
    localparam S_WIN    = 3'd3;
    localparam S_SAMPLE = 3'd4;

    localparam NIN = 12 + DET_W;

    // Two-stage synchronisers on every input except presetn, ce and the APB bus
    wire [NIN-1:0] raw_in = {det_fault, ext_fault, int_fault, ext_sample, ext_discharge,
                             ext_charge_end, ext_charge_begin, local_shot, local_cmd,
                             mode_remote};
    reg  [NIN-1:0] sync1_q;
    reg  [NIN-1:0] sync2_q;
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else if (ce) begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    wire             s_remote = sync2_q[0];
    wire [3:0]       s_lcmd   = sync2_q[4:1];
    wire             s_shot   = sync2_q[5];
    wire [3:0]       s_pulse  = sync2_q[9:6];
    wire             s_int    = sync2_q[10];
    wire             s_ext    = sync2_q[11];
    wire [DET_W-1:0] s_det    = sync2_q[NIN-1:12];

    reg  [4:0] prev_q;
    wire [3:0] pulse_edge = s_pulse & ~prev_q[3:0];
    wire       shot_edge  = s_shot & ~prev_q[4];

    // Register file
    reg  [5:0]  ctrl_q;
    reg  [11:0] rate_q;
    wire        wr_en  = ce & psel & penable & pwrite;
    wire        hit    = (paddr == `OFS_CTRL) | (paddr == `OFS_RATE) |
                         (paddr == `OFS_STATUS) | (paddr == `OFS_FAULT);

    assign pready  = ce;
    assign pslverr = psel & penable & ~hit;

    // Command selection
    wire [3:0] cmd      = s_remote ? ctrl_q[3:0] : s_lcmd;
    wire       cmd_one  = (cmd == 4'h1) | (cmd == 4'h2) | (cmd == 4'h4) | (cmd == 4'h8);
    wire       cmd_many = ~cmd_one & (cmd != 4'h0);
    wire       clr_cmd  = cmd_one & cmd[`CTRL_CLR];

    reg  [1:0]       st_q;
    reg  [DET_W+1:0] lat_q;
    reg              tmg_warn_q;
    reg              cmd_warn_q;
    wire             interlock = |lat_q;

    assign contactor_close    = (st_q != ST_OFF);
    assign electronics_enable = (st_q == ST_RUN);
    assign stat_off           = (st_q == ST_OFF);
    assign stat_standby       = (st_q == ST_STBY);
    assign stat_run           = (st_q == ST_RUN);
    assign remote_healthy     = s_remote & ~interlock;
    assign panel_fault        = lat_q;
    assign indicator = {3'h0, ctrl_q[`CTRL_FREE], cmd_warn_q, tmg_warn_q,
                        lat_q[1], lat_q[0] | (|lat_q[DET_W+1:2])};

    // Millisecond time base
    reg  [`DIV_W-1:0] div_q;
    wire              ms_tick = (div_q == MS_CYC - 1);

    // Local timing simulator
    reg  [11:0] sim_cnt_q;
    wire [11:0] period = (rate_q < `RATE_MIN_MS) ? `RATE_MIN_MS :
                         (rate_q > `RATE_MAX_MS) ? `RATE_MAX_MS : rate_q;
    wire        wr_shot = wr_en & (paddr == `OFS_CTRL) & pwdata[`CTRL_SHOT];
    wire        sim_free_fire = ctrl_q[`CTRL_FREE] & ms_tick & (sim_cnt_q >= period - 12'h001);
    wire        sim_cb = sim_free_fire | wr_shot | (shot_edge & ~s_remote);

    // Pulse sequencer
    reg  [2:0]  seq_q;
    reg  [11:0] ms_q;
    wire        run_tmg = (st_q == ST_RUN);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q               <= 5'h00;
            ctrl_q               <= `CTRL_RST;
            rate_q               <= `RATE_RST;
            prdata               <= 32'h0000_0000;
            st_q                 <= ST_OFF;
            lat_q                <= {(DET_W+2){1'b0}};
            tmg_warn_q           <= 1'b0;
            cmd_warn_q           <= 1'b0;
            div_q                <= {`DIV_W{1'b0}};
            sim_cnt_q            <= 12'h000;
            seq_q                <= S_IDLE;
            ms_q                 <= 12'h000;
            charge_active        <= 1'b0;
            charge_begin_pulse   <= 1'b0;
            charge_end_pulse     <= 1'b0;
            discharge_fire_pulse <= 1'b0;
            sample_pulse         <= 1'b0;
        end else if (ce) begin
            prev_q <= {s_shot, s_pulse};

            // Register bus
            if (wr_en && paddr == `OFS_CTRL) begin
                ctrl_q <= {1'b0, pwdata[4:0]};
            end
            if (wr_en && paddr == `OFS_RATE) begin
                rate_q <= pwdata[11:0];
            end
            if (psel && !penable) begin
                case (paddr)
                    `OFS_CTRL:   prdata <= {26'h0, ctrl_q};
                    `OFS_RATE:   prdata <= {20'h0, rate_q};
                    `OFS_STATUS: prdata <= {16'h0, indicator, seq_q, s_remote,
                                            remote_healthy, stat_run, stat_standby, stat_off};
                    `OFS_FAULT:  prdata <= {{(30-DET_W){1'b0}}, lat_q};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end

            // Interlock memories, set wins over clear
            lat_q <= (clr_cmd ? {(DET_W+2){1'b0}} : lat_q) | {s_det, s_ext, s_int};
            if (clr_cmd) begin
                tmg_warn_q <= 1'b0;
                cmd_warn_q <= cmd_many;
            end else if (cmd_many) begin
                cmd_warn_q <= 1'b1;
            end

            // Converter state
            if (s_lcmd[`CTRL_OFF] || interlock) begin
                st_q <= ST_OFF;
            end else if (cmd_one) begin
                case (cmd)
                    4'h1:    st_q <= ST_OFF;
                    4'h2:    st_q <= ST_STBY;
                    4'h4:    st_q <= ST_RUN;
                    default: st_q <= st_q;
                endcase
            end

            // Time bases
            div_q <= ms_tick ? {`DIV_W{1'b0}} : div_q + 1'b1;
            if (!ctrl_q[`CTRL_FREE] || sim_free_fire) begin
                sim_cnt_q <= 12'h000;
            end else if (ms_tick) begin
                sim_cnt_q <= sim_cnt_q + 12'h001;
            end
            if (ms_tick && ms_q != 12'hFFF) begin
                ms_q <= ms_q + 12'h001;
            end

            charge_begin_pulse   <= 1'b0;
            charge_end_pulse     <= 1'b0;
            discharge_fire_pulse <= 1'b0;
            sample_pulse         <= 1'b0;

            // Timing inhibited outside run
            if (!run_tmg) begin
                seq_q         <= S_IDLE;
                charge_active <= 1'b0;
            end else begin
                case (seq_q)
                    S_IDLE: begin
                        if (pulse_edge[0] || sim_cb) begin
                            seq_q              <= S_CHARGE;
                            ms_q               <= 12'h000;
                            charge_active      <= 1'b1;
                            charge_begin_pulse <= 1'b1;
                        end
                    end
                    S_CHARGE: begin
                        // Other pulses ignored here
                        if (pulse_edge[1] || ms_q >= `CHARGE_GUARD_MS) begin
                            seq_q            <= S_BLOCK;
                            ms_q             <= 12'h000;
                            charge_active    <= 1'b0;
                            charge_end_pulse <= 1'b1;
                            if (!pulse_edge[1]) begin
                                tmg_warn_q <= 1'b1;
                            end
                        end
                    end
                    S_BLOCK: begin
                        if (ms_q >= `BLOCK_MS) begin
                            seq_q <= S_WIN;
                        end
                    end
                    S_WIN: begin
                        if (pulse_edge[2] || ms_q >= `WIN_MS - `RECOV_MS) begin
                            seq_q                <= S_SAMPLE;
                            ms_q                 <= 12'h000;
                            discharge_fire_pulse <= 1'b1;
                            if (!pulse_edge[2]) begin
                                tmg_warn_q <= 1'b1;
                            end
                        end
                    end
                    S_SAMPLE: begin
                        if (pulse_edge[3] || ms_q >= `SAMPLE_GUARD_MS) begin
                            seq_q        <= S_IDLE;
                            sample_pulse <= 1'b1;
                            if (!pulse_edge[3]) begin
                                tmg_warn_q <= 1'b1;
                            end
                        end
                    end
                    default: seq_q <= S_IDLE;
                endcase
            end
        end
    end

endmodule // pulsed_converter_control_sequencer

//--- sim/pcs_chk.sv
`timescale 1ns/100ps
module pcs_chk #(
    parameter DET_W  = 4,
    parameter MS_CYC = 10
) (
    input wire       pclk,
    input wire       presetn,
    input wire       contactor_close,
    input wire       electronics_enable,
    input wire       stat_off,
    input wire       stat_standby,
    input wire       stat_run,
    input wire       remote_healthy,
    input wire [7:0] indicator,
    input wire       charge_active,
    input wire       charge_begin_pulse,
    input wire       charge_end_pulse,
    input wire       discharge_fire_pulse,
    input wire       sample_pulse
);
    localparam int WIN_C = 12 * MS_CYC;
    localparam int SMP_C = 7 * MS_CYC;
    logic [15:0] since_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the last charge-end pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) since_q <= 16'hFFFF;
        else if (charge_end_pulse) since_q <= 16'h0000;
        else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
    end
    sequence end_s; charge_end_pulse; endsequence
    sequence fire_s; ##[1:WIN_C] discharge_fire_pulse; endsequence
    sequence smp_s; ##[1:SMP_C] sample_pulse; endsequence
    off_open_a: assert property (stat_off |-> !contactor_close && !electronics_enable)
        else $error("contactor closed in off");
    stby_out_a: assert property (stat_standby |-> contactor_close && !electronics_enable
        && !charge_begin_pulse)
        else $error("standby outputs wrong");
    run_out_a: assert property (stat_run |-> contactor_close && electronics_enable)
        else $error("run outputs wrong");
    state_onehot_a: assert property ($onehot({stat_off, stat_standby, stat_run}))
        else $error("state bits not one-hot");
    healthy_a: assert property (remote_healthy |-> indicator[1:0] == 2'b00)
        else $error("healthy with fault");
    spare_ind_a: assert property (indicator[7:5] == 3'b000)
        else $error("spare indicators set");
    charge_block_a: assert property (charge_active |-> !discharge_fire_pulse && !sample_pulse)
        else $error("pulse passed during charge");
    fire_win_a: assert property (discharge_fire_pulse |-> since_q >= MS_CYC
        && since_q <= 11 * MS_CYC)
        else $error("discharge outside window");
    seq_order_a: assert property (end_s |-> fire_s)
        else $error("no discharge after charge end");
    fire_sample_a: assert property (discharge_fire_pulse |-> smp_s)
        else $error("no sample after discharge");
endmodule // pcs_chk

bind pulsed_converter_control_sequencer pcs_chk #(.DET_W(DET_W), .MS_CYC(MS_CYC)) u_pcs_chk (.*);

//--- sim/timing_src.sv
`timescale 1ns/100ps
module timing_src #(
    parameter MS_CYC = 10
) (
    input  wire       pclk,
    input  wire       go,
    input  wire [3:0] mask,
    output wire       ext_charge_begin,
    output wire       ext_charge_end,
    output wire       ext_discharge,
    output wire       ext_sample
);
    logic [3:0] p = 4'h0;
    logic [3:0] m;
    assign {ext_sample, ext_discharge, ext_charge_end, ext_charge_begin} = p;
    // Four-cycle pulses, idle low; a cleared mask bit drops that pulse, except the early discharge pulse sent during charge
    task emit(input int k, input int gap, input logic en);
        repeat (gap) @(posedge pclk);
        p[k] <= en;
        repeat (4) @(posedge pclk);
        p[k] <= 1'b0;
    endtask
    always begin
        @(posedge pclk);
        if (go) begin
            m = mask;
            emit(0, 0, m[0]);
            emit(2, 10, 1'b1);
            emit(1, 20, m[1]);
            emit(2, 5 * MS_CYC, m[2]);
            emit(3, 2 * MS_CYC, m[3]);
        end
    end
endmodule // timing_src

//--- sim/pulsed_converter_control_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "pulsed_converter_control_sequencer_defines.vh"
module pulsed_converter_control_sequencer_tb_top;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hE8F248FE;
    logic        pready, pslverr, err, mode_remote = 1, local_shot = 0, go = 0;
    logic [3:0]  local_cmd = 4'h0, mask = 4'hF, det_fault = 4'h0, m;
    logic        int_fault = 0, ext_fault = 0, contactor_close, electronics_enable;
    logic        ext_charge_begin, ext_charge_end, ext_discharge, ext_sample, stat_off;
    logic        stat_standby, stat_run, remote_healthy, charge_active, sample_pulse;
    logic        charge_begin_pulse, charge_end_pulse, discharge_fire_pulse;
    logic [7:0]  indicator;
    logic [5:0]  panel_fault;
    int          failures = 0, checks = 0, cyc = 0, n_b = 0, n_e = 0, n_f = 0, n_s = 0;
    pulsed_converter_control_sequencer #(.MS_CYC(10)) u_pulsed_converter_control_sequencer (.*);
    timing_src #(.MS_CYC(10)) u_timing_src (.*);
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        n_b <= n_b + charge_begin_pulse;
        n_e <= n_e + charge_end_pulse;
        n_f <= n_f + discharge_fire_pulse;
        n_s <= n_s + sample_pulse;
        if (cyc == 90000) begin
            failures = failures + 1;
            end_sim;
        end
    end
    function logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function logic exp_warn(input logic [3:0] k);
        exp_warn = ~&k[3:1];
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task st(input logic [2:0] e, input string nm);
        chk({stat_run, stat_standby, stat_off}, e, nm);
    endtask
    task wt(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        int i, k, b0, e0, f0, s0;
        wt(12);
        presetn <= 1;
        wt(2);
        apb(0, `OFS_CTRL, 0);
        chk(rd, 32'h1, "ctrl reset");
        apb(0, 12'h010, 0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        apb(1, `OFS_RATE, 0);
        apb(0, `OFS_RATE, 0);
        chk(rd, 32'h0, "rate write");
        st(3'b001, "reset off");
        apb(1, `OFS_CTRL, 32'h4);
        wt(2);
        st(3'b100, "run");
        apb(0, `OFS_STATUS, 0);
        chk(rd[4:0], 5'h1C, "status");
        local_cmd <= 4'h2;
        wt(5);
        st(3'b100, "remote keeps");
        local_cmd <= 4'h1;
        wt(5);
        st(3'b001, "local off");
        local_cmd <= 4'h0;
        apb(1, `OFS_CTRL, 32'h2);
        wt(2);
        st(3'b010, "standby");
        apb(1, `OFS_CTRL, 32'h6);
        wt(2);
        chk({indicator[3], stat_standby}, 2'b11, "conflict");
        apb(1, `OFS_CTRL, 32'h8);
        wt(2);
        chk(indicator[3], 0, "warn clear");
        for (k = 0; k < 3; k++) begin
            apb(1, `OFS_CTRL, 32'h4);
            {det_fault, ext_fault, int_fault} <= 6'h01 << (k * k);
            wt(4);
            {det_fault, ext_fault, int_fault} <= 6'h00;
            wt(4);
            st(3'b001, "fault off");
            chk({indicator[k == 1], remote_healthy}, 2'b10, "fault ind");
            chk(panel_fault, 6'h01 << (k * k), "panel fault");
            apb(1, `OFS_CTRL, 32'h8);
            wt(3);
            chk({indicator[k == 1], panel_fault}, 0, "fault clear");
        end
        ce <= 0;
        wt(2);
        chk(pready, 0, "ce low");
        ce <= 1;
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            m = (i < 2) ? {3'b111, i == 0} : seed[3:0];
            apb(1, `OFS_CTRL, 32'h8);
            apb(1, `OFS_CTRL, 32'h4);
            if (!m[0]) apb(1, `OFS_CTRL, 32'h24);
            {b0, e0, f0, s0} = {n_b, n_e, n_f, n_s};
            mask <= m;
            go <= 1;
            @(posedge pclk);
            go <= 0;
            for (k = 0; k < 8000 && n_s == s0; k++) @(posedge pclk);
            wt(2);
            chk((n_b-b0)*1000 + (n_e-e0)*100 + (n_f-f0)*10 + n_s-s0, 1111, "seq");
            chk(indicator[2], exp_warn(m), "guard");
        end
        apb(1, `OFS_CTRL, 32'h12);
        wt(2);
        chk(indicator[4], 1, "free run");
        mode_remote <= 0;
        local_cmd <= 4'h4;
        wt(5);
        chk({stat_run, remote_healthy}, 2'b10, "local run");
        local_cmd <= 4'h0;
        apb(1, `OFS_CTRL, 32'h2);
        wt(3);
        st(3'b100, "local ignores");
        {b0, s0} = {n_b, n_s};
        local_shot <= 1;
        for (k = 0; k < 8000 && n_s == s0; k++) @(posedge pclk);
        chk((n_b - b0) * 10 + n_s - s0, 11, "local shot");
        chk(indicator[2], 1, "shot guard");
        end_sim;
    end
endmodule // pulsed_converter_control_sequencer_tb_top
